// File: dscc_self_cal.sv
// top of the self-calibration control block with its three registers
`timescale 1ns/1ps
// ===================================================================
// Notes on behaviour
// - setup bit 3 gates the calibration clock
// - four-bit select picks channels, resets all ones
// - launches hit any mix; bit0 zero, bit2 one
// - done flag bit 7 rises at run end
// - overrange at finish means the reruns ran out, not success
// - active flag bit 6 high during runs
// - bit 5 marks high-side saturation at cycle end
// - bit 4 marks low-side saturation at cycle end
// - overrange shifts preset and reruns the cycle
// - rising start bit launches selected channels
// - enable bit powers engine, gates coefficient use
module dscc_self_cal
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [dscc_pkg::ADDR_W-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [dscc_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_rd,
    output logic [dscc_pkg::DATA_W-1:0] reg_rdata,
    output logic cal_clk_gate,
    input wire logic cmp_hi_ch0,
    input wire logic cmp_hi_ch1,
    output logic [dscc_pkg::CODE_W-1:0] trim_code_ch0,
    output logic [dscc_pkg::CODE_W-1:0] trim_code_ch1,
    output logic [dscc_pkg::PRESET_W-1:0] preset_ch0,
    output logic [dscc_pkg::PRESET_W-1:0] preset_ch1,
    output logic coeff_apply_ch0,
    output logic coeff_apply_ch1
);
    import dscc_pkg::*;

    logic [3:0] clk_upper_r, clk_upper_nxt;
    logic clk_en_r, clk_en_nxt;
    logic [SEL_W-1:0] sel_r, sel_nxt;
    logic [NCH-1:0] en_r, en_nxt;
    logic [NCH-1:0] start_r, start_nxt;
    logic [DATA_W-1:0] rdata_r, rdata_nxt;
    logic [NCH-1:0] cmp_pin;
    logic [NCH-1:0] cmp_sync;
    logic [NCH-1:0] act;
    logic [NCH-1:0] done;
    logic [NCH-1:0] hi;
    logic [NCH-1:0] lo;
    logic [NCH-1:0] apply;
    logic [NCH-1:0][CODE_W-1:0] code;
    logic [NCH-1:0][PRESET_W-1:0] pre;

    // ===================================================================
    // helpers

    // select bit that pages a channel in
    function automatic logic chan_picked(input logic [SEL_W-1:0] sel, input int ch);
        if (ch == 0)
            return sel[SEL_CH0_BIT];
        else
            return sel[SEL_CH1_BIT];
    endfunction

    // status byte of one channel as software reads it
    function automatic logic [DATA_W-1:0] ctrl_byte(input int ch,
        input logic [NCH-1:0] d, input logic [NCH-1:0] a,
        input logic [NCH-1:0] h, input logic [NCH-1:0] l,
        input logic [NCH-1:0] s, input logic [NCH-1:0] e);
        logic [DATA_W-1:0] b;
        b = READ_ZERO;
        b[DONE_BIT] = d[ch];
        b[ACTIVE_BIT] = a[ch];
        b[HI_BIT] = h[ch];
        b[LO_BIT] = l[ch];
        b[START_BIT] = s[ch];
        b[EN_BIT] = e[ch];
        return b;
    endfunction

    // ===================================================================
    // register writes
    always_comb
    begin
        clk_upper_nxt = clk_upper_r;
        clk_en_nxt = clk_en_r;
        sel_nxt = sel_r;
        en_nxt = en_r;
        start_nxt = start_r;
        if (reg_wr)
        begin
            case (reg_addr)
                ADDR_CLK_SETUP:
                begin
                    // upper nibble kept as written; software owns its value
                    clk_upper_nxt = reg_wdata[CLK_UPPER_MSB:CLK_UPPER_LSB];
                    clk_en_nxt = reg_wdata[CLK_EN_BIT];
                end
                ADDR_CHAN_SEL:
                    sel_nxt = reg_wdata[SEL_W-1:0];
                ADDR_CTRL_STAT:
                begin
                    // every paged channel takes the write at once
                    for (int ch = 0; ch < NCH; ch++)
                    begin
                        if (chan_picked(sel_r, ch))
                        begin
                            en_nxt[ch] = reg_wdata[EN_BIT];
                            start_nxt[ch] = reg_wdata[START_BIT];
                        end
                    end
                end
                default:
                    clk_en_nxt = clk_en_r;
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            clk_upper_r <= CLK_UPPER_RST;
            clk_en_r <= 1'b0;
            sel_r <= SEL_RST;
            en_r <= '0;
            start_r <= '0;
        end
        else
        begin
            clk_upper_r <= clk_upper_nxt;
            clk_en_r <= clk_en_nxt;
            sel_r <= sel_nxt;
            en_r <= en_nxt;
            start_r <= start_nxt;
        end
    end

    // ===================================================================
    // register reads, answered one cycle after the strobe
    always_comb
    begin
        rdata_nxt = rdata_r;
        if (reg_rd)
        begin
            rdata_nxt = READ_ZERO;
            case (reg_addr)
                ADDR_CLK_SETUP:
                begin
                    rdata_nxt[CLK_UPPER_MSB:CLK_UPPER_LSB] = clk_upper_r;
                    rdata_nxt[CLK_EN_BIT] = clk_en_r;
                end
                ADDR_CHAN_SEL:
                    rdata_nxt[SEL_W-1:0] = sel_r;
                ADDR_CTRL_STAT:
                begin
                    // with both bits set channel zero wins; one bit is expected
                    if (chan_picked(sel_r, 0))
                        rdata_nxt = ctrl_byte(0, done, act, hi, lo, start_r, en_r);
                    else if (chan_picked(sel_r, 1))
                        rdata_nxt = ctrl_byte(1, done, act, hi, lo, start_r, en_r);
                end
                default:
                    rdata_nxt = READ_ZERO;
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            rdata_r <= READ_ZERO;
        else
            rdata_r <= rdata_nxt;
    end

    // ===================================================================
    // per-channel comparator sync and calibration engines
    assign cmp_pin[0] = cmp_hi_ch0;
    assign cmp_pin[1] = cmp_hi_ch1;

    for (genvar ch = 0; ch < NCH; ch++)
    begin : g_chan
        dscc_sync2 u_sync
        (
            .clk(clk),
            .arst_n(arst_n),
            .async_in(cmp_pin[ch]),
            .sync_out(cmp_sync[ch])
        );

        dscc_cal_engine u_engine
        (
            .clk(clk),
            .arst_n(arst_n),
            .cal_en(en_r[ch]),
            .start_lvl(start_r[ch]),
            .clk_en(clk_en_r),
            .cmp_hi(cmp_sync[ch]),
            .active(act[ch]),
            .done(done[ch]),
            .err_hi(hi[ch]),
            .err_lo(lo[ch]),
            .coeff_apply(apply[ch]),
            .trim_code(code[ch]),
            .preset(pre[ch])
        );
    end

    // ===================================================================
    // outputs, all straight from flip-flops
    assign reg_rdata = rdata_r;
    assign cal_clk_gate = clk_en_r;
    assign trim_code_ch0 = code[0];
    assign trim_code_ch1 = code[1];
    assign preset_ch0 = pre[0];
    assign preset_ch1 = pre[1];
    assign coeff_apply_ch0 = apply[0];
    assign coeff_apply_ch1 = apply[1];

    // ===================================================================
    // checks
    property p_clk_gate;
        @(posedge clk) disable iff (!arst_n)
        (reg_wr && reg_addr == ADDR_CLK_SETUP)
        |=> cal_clk_gate == $past(reg_wdata[CLK_EN_BIT]);
    endproperty
    a_clk_gate: assert property (p_clk_gate) else $error("clock gate missed write");

    property p_sel_read;
        @(posedge clk) disable iff (!arst_n)
        (reg_rd && !reg_wr && reg_addr == ADDR_CHAN_SEL)
        |=> reg_rdata == {{(DATA_W-SEL_W){1'b0}}, $past(sel_r)};
    endproperty
    a_sel_read: assert property (p_sel_read) else $error("select readback wrong");

    property p_wr_both;
        @(posedge clk) disable iff (!arst_n)
        (reg_wr && reg_addr == ADDR_CTRL_STAT && sel_r[SEL_CH0_BIT] && sel_r[SEL_CH1_BIT])
        |=> en_r == {NCH{$past(reg_wdata[EN_BIT])}} && start_r == {NCH{$past(reg_wdata[START_BIT])}};
    endproperty
    a_wr_both: assert property (p_wr_both) else $error("paged write missed a channel");

    property p_wr_skip;
        @(posedge clk) disable iff (!arst_n)
        (reg_wr && reg_addr == ADDR_CTRL_STAT && !sel_r[SEL_CH1_BIT])
        |=> $stable(en_r[1]) && $stable(start_r[1]);
    endproperty
    a_wr_skip: assert property (p_wr_skip) else $error("unpaged channel written");

    property p_stat_read;
        @(posedge clk) disable iff (!arst_n)
        (reg_rd && reg_addr == ADDR_CTRL_STAT && sel_r[SEL_CH1_BIT] && !sel_r[SEL_CH0_BIT])
        |=> reg_rdata[DONE_BIT] == $past(done[1]) && reg_rdata[ACTIVE_BIT] == $past(act[1])
            && reg_rdata[HI_BIT] == $past(hi[1]) && reg_rdata[LO_BIT] == $past(lo[1]);
    endproperty
    a_stat_read: assert property (p_stat_read) else $error("status readback wrong");

    property p_launch_top;
        @(posedge clk) disable iff (!arst_n)
        (reg_wr && reg_addr == ADDR_CTRL_STAT && sel_r[SEL_CH0_BIT] && reg_wdata[START_BIT]
         && reg_wdata[EN_BIT] && !start_r[0] && !act[0])
        |=> ##1 act[0];
    endproperty
    a_launch_top: assert property (p_launch_top) else $error("start write did not launch");

    property p_launch_ch1;
        @(posedge clk) disable iff (!arst_n)
        (reg_wr && reg_addr == ADDR_CTRL_STAT && sel_r[SEL_CH1_BIT] && reg_wdata[START_BIT]
         && reg_wdata[EN_BIT] && !start_r[1] && !act[1])
        |=> ##1 act[1];
    endproperty
    a_launch_ch1: assert property (p_launch_ch1) else $error("channel one launch missed");

    // gate changes only through a setup write
    property p_gate_hold;
        @(posedge clk) disable iff (!arst_n)
        !(reg_wr && reg_addr == ADDR_CLK_SETUP) |=> $stable(cal_clk_gate);
    endproperty
    a_gate_hold: assert property (p_gate_hold) else $error("clock gate moved without write");

    // channel zero readback, the case software uses most
    property p_stat_ch0;
        @(posedge clk) disable iff (!arst_n)
        (reg_rd && reg_addr == ADDR_CTRL_STAT && sel_r[SEL_CH0_BIT])
        |=> reg_rdata[ACTIVE_BIT] == $past(act[0]) && reg_rdata[DONE_BIT] == $past(done[0])
            && reg_rdata[EN_BIT] == $past(en_r[0]);
    endproperty
    a_stat_ch0: assert property (p_stat_ch0) else $error("channel zero status wrong");

    // addresses outside the three mapped registers read as zero
    property p_unmapped;
        @(posedge clk) disable iff (!arst_n)
        (reg_rd && reg_addr != ADDR_CLK_SETUP && reg_addr != ADDR_CHAN_SEL
         && reg_addr != ADDR_CTRL_STAT)
        |=> reg_rdata == READ_ZERO;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

    // coefficients lag the enable by one register stage, never more
    property p_apply_top;
        @(posedge clk) disable iff (!arst_n)
        coeff_apply_ch1 |-> $past(en_r[1]) && done[1] && !hi[1] && !lo[1];
    endproperty
    a_apply_top: assert property (p_apply_top) else $error("channel one coefficients wrong");
endmodule

// File: dscc_pkg.sv
// shared constants, register map and types of the calibration control block
package dscc_pkg;
    // ===================================================================
    // register access port
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
    localparam logic [ADDR_W-1:0] ADDR_CLK_SETUP = 12'h0e7;
    localparam logic [ADDR_W-1:0] ADDR_CHAN_SEL = 12'h0e8;
    localparam logic [ADDR_W-1:0] ADDR_CTRL_STAT = 12'h0e9;
    localparam logic [DATA_W-1:0] READ_ZERO = 8'h00;
    // ===================================================================
    // cal_clock_setup fields
    localparam int CLK_UPPER_MSB = 7;
    localparam int CLK_UPPER_LSB = 4;
    localparam int CLK_EN_BIT = 3;
    localparam logic [3:0] CLK_UPPER_RST = 4'h3;
    // ===================================================================
    // cal_channel_select fields
    localparam int SEL_W = 4;
    localparam logic [SEL_W-1:0] SEL_RST = 4'hf;
    localparam int SEL_CH0_BIT = 0;
    localparam int SEL_CH1_BIT = 2;
    // ===================================================================
    // cal_control_status fields
    localparam int DONE_BIT = 7;
    localparam int ACTIVE_BIT = 6;
    localparam int HI_BIT = 5;
    localparam int LO_BIT = 4;
    localparam int START_BIT = 1;
    localparam int EN_BIT = 0;
    // ===================================================================
    // engine sizing and timing
    localparam int NCH = 2;
    localparam int CODE_W = 8;
    localparam int BIT_W = 3;
    localparam logic [BIT_W-1:0] CODE_MSB = 3'h7;
    localparam int PRESET_W = 4;
    localparam int RETRY_W = 2;
    localparam logic [RETRY_W-1:0] MAX_RETRY = 2'h3;
    localparam int CLK_MHZ = 100;
    localparam int SETTLE_NS = 200;
    localparam int SETTLE_W = 5;
    localparam logic [SETTLE_W-1:0] SETTLE_CYC =
        SETTLE_W'((SETTLE_NS * CLK_MHZ + 999) / 1000);
    // ===================================================================
    // engine states
    typedef enum logic [1:0]
    {
        ST_IDLE = 2'b00,
        ST_TRIAL = 2'b01,
        ST_DECIDE = 2'b10,
        ST_CHECK = 2'b11
    } dscc_state_type;
endpackage

// File: dscc_sync2.sv
// two flip-flop synchroniser for one asynchronous level
`timescale 1ns/1ps
module dscc_sync2
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic async_in,
    output logic sync_out
);
    logic meta_r;
    logic sync_r;

    // first stage feeds only the second stage
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
        end
        else
        begin
            meta_r <= async_in;
            sync_r <= meta_r;
        end
    end

    assign sync_out = sync_r;
endmodule

// File: dscc_cal_engine.sv
// per-channel successive approximation calibration engine
`timescale 1ns/1ps
module dscc_cal_engine
    import dscc_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic cal_en,
    input wire logic start_lvl,
    input wire logic clk_en,
    input wire logic cmp_hi,
    output logic active,
    output logic done,
    output logic err_hi,
    output logic err_lo,
    output logic coeff_apply,
    output logic [CODE_W-1:0] trim_code,
    output logic [PRESET_W-1:0] preset
);
    dscc_state_type state_r, state_nxt;
    logic [CODE_W-1:0] code_r, code_nxt;
    logic [BIT_W-1:0] bit_r, bit_nxt;
    logic [SETTLE_W-1:0] settle_r, settle_nxt;
    logic [RETRY_W-1:0] retry_r, retry_nxt;
    logic [PRESET_W-1:0] preset_r, preset_nxt;
    logic start_d_r, act_r, act_nxt, done_r, done_nxt;
    logic hi_r, hi_nxt, lo_r, lo_nxt, apply_r, apply_nxt;
    logic start_rise;

    function automatic logic sat_high(input logic [CODE_W-1:0] c);
        return &c;
    endfunction

    function automatic logic sat_low(input logic [CODE_W-1:0] c);
        return ~|c;
    endfunction

    assign start_rise = start_lvl & ~start_d_r;

    // ===================================================================
    // sequencer; every step past launch waits for the gated cal clock
    always_comb
    begin
        state_nxt = state_r;
        code_nxt = code_r;
        bit_nxt = bit_r;
        settle_nxt = settle_r;
        retry_nxt = retry_r;
        preset_nxt = preset_r;
        act_nxt = act_r;
        done_nxt = done_r;
        hi_nxt = hi_r;
        lo_nxt = lo_r;
        case (state_r)
            ST_IDLE:
            begin
                if (start_rise && cal_en)
                begin
                    act_nxt = 1'b1;
                    done_nxt = 1'b0;
                    hi_nxt = 1'b0;
                    lo_nxt = 1'b0;
                    retry_nxt = '0;
                    code_nxt = '0;
                    code_nxt[CODE_MSB] = 1'b1;
                    bit_nxt = CODE_MSB;
                    settle_nxt = SETTLE_CYC;
                    state_nxt = ST_TRIAL;
                end
            end
            ST_TRIAL:
            begin
                if (clk_en)
                begin
                    if (settle_r == '0)
                        state_nxt = ST_DECIDE;
                    else
                        settle_nxt = settle_r - 1'b1;
                end
            end
            ST_DECIDE:
            begin
                if (clk_en)
                begin
                    if (cmp_hi)
                        code_nxt[bit_r] = 1'b0;
                    if (bit_r == '0)
                        state_nxt = ST_CHECK;
                    else
                    begin
                        bit_nxt = bit_r - 1'b1;
                        code_nxt[bit_r - 1'b1] = 1'b1;
                        settle_nxt = SETTLE_CYC;
                        state_nxt = ST_TRIAL;
                    end
                end
            end
            ST_CHECK:
            begin
                if (clk_en)
                begin
                    hi_nxt = sat_high(code_r);
                    lo_nxt = sat_low(code_r);
                    if ((hi_nxt || lo_nxt) && retry_r != MAX_RETRY)
                    begin
                        // shift the preset away from the rail and run again
                        if (hi_nxt && preset_r != '1)
                            preset_nxt = preset_r + 1'b1;
                        else if (lo_nxt && preset_r != '0)
                            preset_nxt = preset_r - 1'b1;
                        retry_nxt = retry_r + 1'b1;
                        code_nxt = '0;
                        code_nxt[CODE_MSB] = 1'b1;
                        bit_nxt = CODE_MSB;
                        settle_nxt = SETTLE_CYC;
                        state_nxt = ST_TRIAL;
                    end
                    else
                    begin
                        done_nxt = 1'b1;
                        act_nxt = 1'b0;
                        state_nxt = ST_IDLE;
                    end
                end
            end
            default:
                state_nxt = ST_IDLE;
        endcase
        // dropping the enable abandons a run without a result
        if (!cal_en)
        begin
            // an abort in the check cycle must not post a result
            act_nxt = 1'b0;
            done_nxt = done_r;
            hi_nxt = hi_r;
            lo_nxt = lo_r;
            state_nxt = ST_IDLE;
        end
        apply_nxt = cal_en && done_nxt && !hi_nxt && !lo_nxt;
    end

    // ===================================================================
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_r <= ST_IDLE;
            code_r <= '0;
            bit_r <= '0;
            settle_r <= '0;
            retry_r <= '0;
            preset_r <= '0;
            start_d_r <= 1'b0;
            act_r <= 1'b0;
            done_r <= 1'b0;
            hi_r <= 1'b0;
            lo_r <= 1'b0;
            apply_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            code_r <= code_nxt;
            bit_r <= bit_nxt;
            settle_r <= settle_nxt;
            retry_r <= retry_nxt;
            preset_r <= preset_nxt;
            start_d_r <= start_lvl;
            act_r <= act_nxt;
            done_r <= done_nxt;
            hi_r <= hi_nxt;
            lo_r <= lo_nxt;
            apply_r <= apply_nxt;
        end
    end

    assign active = act_r;
    assign done = done_r;
    assign err_hi = hi_r;
    assign err_lo = lo_r;
    assign coeff_apply = apply_r;
    assign trim_code = code_r;
    assign preset = preset_r;

    // ===================================================================
    // checks
    property p_launch;
        @(posedge clk) disable iff (!arst_n)
        (start_lvl && !start_d_r && cal_en && state_r == ST_IDLE) |=> act_r && !done_r;
    endproperty
    a_launch: assert property (p_launch) else $error("launch did not start run");

    property p_done_idle;
        @(posedge clk) disable iff (!arst_n)
        $rose(done_r) |-> !act_r && $past(act_r);
    endproperty
    a_done_idle: assert property (p_done_idle) else $error("done without run end");

    property p_active_run;
        @(posedge clk) disable iff (!arst_n)
        (state_r != ST_IDLE) |-> act_r;
    endproperty
    a_active_run: assert property (p_active_run) else $error("run without active");

    property p_hi_sat;
        @(posedge clk) disable iff (!arst_n)
        $rose(done_r) && hi_r |-> sat_high(code_r);
    endproperty
    a_hi_sat: assert property (p_hi_sat) else $error("high flag without high rail");

    property p_lo_sat;
        @(posedge clk) disable iff (!arst_n)
        $rose(done_r) && lo_r |-> sat_low(code_r);
    endproperty
    a_lo_sat: assert property (p_lo_sat) else $error("low flag without low rail");

    property p_retry;
        @(posedge clk) disable iff (!arst_n)
        (state_r == ST_CHECK && clk_en && cal_en && sat_high(code_r) &&
         retry_r != MAX_RETRY && preset_r != '1)
        |=> state_r == ST_TRIAL && preset_r == $past(preset_r) + 1'b1;
    endproperty
    a_retry: assert property (p_retry) else $error("no rerun after overrange");

    property p_apply;
        @(posedge clk) disable iff (!arst_n)
        apply_r |-> $past(cal_en) && done_r && !hi_r && !lo_r;
    endproperty
    a_apply: assert property (p_apply) else $error("coefficients applied wrongly");

    property p_stall;
        @(posedge clk) disable iff (!arst_n)
        (state_r != ST_IDLE && !clk_en && cal_en) |=> $stable(code_r) && $stable(state_r);
    endproperty
    a_stall: assert property (p_stall) else $error("engine moved with clock off");

    property p_disabled;
        @(posedge clk) disable iff (!arst_n)
        !cal_en |=> !act_r && !apply_r;
    endproperty
    a_disabled: assert property (p_disabled) else $error("engine ran while disabled");
endmodule

// File: dscc_self_cal_bench.sv
// self-checking register-level bench of the calibration control block
`timescale 1ns/1ps
module dscc_self_cal_bench import dscc_pkg::*;;
    logic clk, arst_n, reg_wr, reg_rd, cmp_hi_ch0, cmp_hi_ch1, cal_clk_gate;
    logic coeff_apply_ch0, coeff_apply_ch1;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata, reg_rdata, rd_val;
    logic [CODE_W-1:0] trim_code_ch0, trim_code_ch1, tgt0, tgt1;
    logic [PRESET_W-1:0] preset_ch0, preset_ch1;
    int n_mismatch, samples_checked;
    // ===================================================================
    // device under test
    dscc_self_cal DUT (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .cal_clk_gate(cal_clk_gate), .cmp_hi_ch0(cmp_hi_ch0), .cmp_hi_ch1(cmp_hi_ch1),
        .trim_code_ch0(trim_code_ch0), .trim_code_ch1(trim_code_ch1),
        .preset_ch0(preset_ch0), .preset_ch1(preset_ch1),
        .coeff_apply_ch0(coeff_apply_ch0), .coeff_apply_ch1(coeff_apply_ch1));
    // ===================================================================
    // clock, comparator stand-ins and watchdog
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // ideal comparators: trial above target means too high, so the code homes on target
    always @(negedge clk)
    begin
        cmp_hi_ch0 <= (trim_code_ch0 > tgt0);
        cmp_hi_ch1 <= (trim_code_ch1 > tgt1);
    end
    // a few runs of some 180 to 700 cycles each fit easily in this span
    initial
    begin
        #200us;
        n_mismatch++;
        $display("mismatch at %0t: watchdog expired", $time);
        summarize();
    end
    // ===================================================================
    // access tasks
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        samples_checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(negedge clk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk);
        reg_wr = 1'b0;
    endtask
    // data is sampled a cycle and a half after the read edge, where it has settled
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(negedge clk);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge clk);
        reg_rd = 1'b0;
        @(negedge clk);
        d = reg_rdata;
    endtask
    // start needs a fresh rising edge, so it is written low first
    task automatic launch(input logic [DATA_W-1:0] sel);
        wr(ADDR_CHAN_SEL, sel);
        wr(ADDR_CTRL_STAT, 8'h01);
        wr(ADDR_CTRL_STAT, 8'h03);
    endtask
    // bounded poll of the finished flag of the channel currently selected
    task automatic wait_done();
        int i;
        rd_val = 8'h00;
        for (i = 0; i < 600 && rd_val[DONE_BIT] !== 1'b1; i++)
            rd(ADDR_CTRL_STAT, rd_val);
    endtask
    task automatic summarize();
        $display("checks %0d, mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // ===================================================================
    // test sequence
    initial
    begin
        arst_n = 1'b0;
        reg_addr = '0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = '0;
        tgt0 = 8'h5a;
        tgt1 = 8'ha5;
        cmp_hi_ch0 = 1'b0;
        cmp_hi_ch1 = 1'b0;
        n_mismatch = 0;
        samples_checked = 0;
        repeat (2) @(posedge clk);
        @(negedge clk);
        arst_n = 1'b1;
        // reset values and read-only corners
        chk(cal_clk_gate, 8'h00, "gate after reset");
        rd(ADDR_CLK_SETUP, rd_val); chk(rd_val, 8'h30, "setup reset");
        rd(ADDR_CHAN_SEL, rd_val); chk(rd_val, 8'h0f, "select reset");
        wr(ADDR_CHAN_SEL, 8'h01);
        rd(ADDR_CTRL_STAT, rd_val); chk(rd_val, 8'h00, "status reset");
        wr(12'h0ed, 8'ha2);
        rd(12'h0ed, rd_val); chk(rd_val, READ_ZERO, "unmapped read");
        wr(ADDR_CLK_SETUP, 8'h3f);
        rd(ADDR_CLK_SETUP, rd_val); chk(rd_val, 8'h38, "setup low bits read only");
        chk(cal_clk_gate, 8'h01, "gate on");
        // both channels launched together, each read back alone
        launch(8'h05);
        wr(ADDR_CHAN_SEL, 8'h01);
        rd(ADDR_CTRL_STAT, rd_val); chk(rd_val, 8'h43, "active while running");
        wait_done();
        chk(rd_val, 8'h83, "ch0 finished clean");
        wr(ADDR_CHAN_SEL, 8'h04);
        rd(ADDR_CTRL_STAT, rd_val); chk(rd_val, 8'h83, "ch1 finished clean");
        chk(trim_code_ch0, tgt0, "ch0 code");
        chk(trim_code_ch1, tgt1, "ch1 code");
        chk({coeff_apply_ch1, coeff_apply_ch0}, 8'h03, "coefficients applied");
        // dropping enable withdraws the coefficients
        wr(ADDR_CHAN_SEL, 8'h05);
        wr(ADDR_CTRL_STAT, 8'h02);
        repeat (2) @(negedge clk);
        chk({coeff_apply_ch1, coeff_apply_ch0}, 8'h00, "coefficients off");
        // saturation high on channel zero only, with preset reruns
        tgt0 = 8'hff;
        launch(8'h01);
        wait_done();
        chk(rd_val, 8'ha3, "high overrange status");
        chk(preset_ch0, 8'h03, "preset raised per rerun");
        chk(coeff_apply_ch0, 8'h00, "overrange not applied");
        wr(ADDR_CHAN_SEL, 8'h04);
        rd(ADDR_CTRL_STAT, rd_val); chk(rd_val, 8'h82, "ch1 untouched");
        chk(preset_ch1, 8'h00, "ch1 preset untouched");
        // saturation low walks the preset back down
        tgt0 = 8'h00;
        launch(8'h01);
        wait_done();
        chk(rd_val, 8'h93, "low overrange status");
        chk(preset_ch0, 8'h00, "preset lowered per rerun");
        // with the clock gated the run cannot advance; enable off aborts it
        wr(ADDR_CLK_SETUP, 8'h30);
        chk(cal_clk_gate, 8'h00, "gate off");
        launch(8'h01);
        repeat (300) @(negedge clk);
        rd(ADDR_CTRL_STAT, rd_val); chk(rd_val, 8'h43, "stalled without clock");
        wr(ADDR_CTRL_STAT, 8'h00);
        rd(ADDR_CTRL_STAT, rd_val); chk(rd_val, 8'h00, "abort by enable");
        summarize();
    end
endmodule
